// [boot_config_loader.sv]
// Purpose: copies the configuration image out of a byte-wide boot memory after reset
// Assumes: ref_clk is the bus clock, rst_b is the bus reset, boot memory answers in 8 clocks
// Notes: loaded bytes leave through an 8-entry buffer; bus config accesses stall until done
//
// Overview of operation
// - add-on reset follows bus reset both ways
// - reset puts every setting at its default
// - config accesses wait until load ends
// - select low means byte-wide boot memory
// - select high means serial or none
// - present address 0040h right after reset
// - sample after eight clocks, then next address
// - both id bytes FFh keeps defaults
// - otherwise read signature 0050h to 0053h
// - signature must be C0-C2, FFh, E8h, 10h
// - valid memory copied 0040h to 007Fh
// - byte 0045h sets options, not registers
// - finished load lets accesses complete
// - bar0 low byte picks io, memory, below 1M
`timescale 1ns/1ps

// plain synchronous fifo; all state sits in one struct
module cfg_byte_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic full;
      logic empty;
   } fifo_t;
   fifo_t s;
   fifo_t next_s;
   logic push;
   logic pop;

   assign in_ready = !s.full;
   assign out_valid = !s.empty;
   assign out_data = s.mem[s.rd_ptr];
   assign push = in_valid && !s.full;
   assign pop = out_ready && !s.empty;

   // pointers wrap naturally because depth is a power of two
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr_ptr] = in_data;
         next_s.wr_ptr = s.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_s.rd_ptr = s.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_s.count = s.count + 1'b1;
      end else if (pop && !push) begin
         next_s.count = s.count - 1'b1;
      end
      next_s.full = next_s.count == (AW+1)'(DEPTH);
      next_s.empty = next_s.count == '0;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, full: 1'b0, empty: 1'b1};
      end else begin
         s <= next_s;
      end
   end
endmodule

module boot_config_loader
   import boot_loader_pkg::*;
#(
   parameter logic [7:0] BAR0_DEFAULT = boot_loader_pkg::BAR0_RESET
) (
   // clock and bus reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // add-on reset
   output logic addon_reset_out_n,
   // boot memory pins
   input wire logic boot_type_select,
   output logic [15:0] boot_mem_addr,
   input wire logic [7:0] boot_mem_rdata,
   // bus configuration access handshake
   input wire logic cfg_req,
   output logic cfg_stall,
   output logic cfg_trdy,
   // loaded image bytes toward the configuration registers
   output logic cfg_wr_valid,
   output logic [boot_loader_pkg::OFS_W-1:0] cfg_wr_offset,
   output logic [7:0] cfg_wr_data,
   input wire logic cfg_wr_ready,
   // settings decided by the load
   output logic boot_valid,
   output logic [7:0] bar0_low,
   output logic bar0_io,
   output logic bar0_below_1m,
   output logic [7:0] opt_byte
);
   import boot_loader_pkg::*;

   typedef struct packed {
      load_state_t st;
      logic [15:0] addr;
      logic [3:0] cnt;
      logic lo_erased;
      logic [7:0] bar_tmp;
      logic [7:0] opt_tmp;
      logic [7:0] rd_meta;
      logic [7:0] rd_sync;
      logic sel_meta;
      logic sel_sync;
      logic rst_out_n;
      logic stall;
      logic trdy;
      logic valid;
      logic [7:0] bar;
      logic io;
      logic low1m;
      logic [7:0] opt;
   } loader_t;
   loader_t s;
   loader_t next_s;
   logic sample;
   logic push;
   logic fifo_ready;
   logic fifo_valid;
   logic [ENTRY_W-1:0] fifo_out;
   logic sig_ok;

   assign sample = s.cnt == WAIT_LAST;
   // option byte stays inside the block instead of going to the registers
   assign push = s.st == ST_COPY && sample && s.addr != OPT_ADDR;

   // signature check, one byte per value of the two low address bits
   always_comb begin
      unique case (s.addr[1:0])
         2'h0: sig_ok = s.rd_sync == BAR0_MEM || s.rd_sync == BAR0_IO
                        || s.rd_sync == BAR0_LOW1M;
         2'h1: sig_ok = s.rd_sync == SIG1_BYTE;
         2'h2: sig_ok = s.rd_sync == SIG2_BYTE;
         2'h3: sig_ok = s.rd_sync == SIG3_BYTE;
      endcase
   end

   // load sequencer; the boot memory pin inputs are read only through their second flop, cfg_req directly
   always_comb begin
      next_s = s;
      next_s.rd_meta = boot_mem_rdata;
      next_s.rd_sync = s.rd_meta;
      next_s.sel_meta = boot_type_select;
      next_s.sel_sync = s.sel_meta;
      next_s.rst_out_n = 1'b1;
      next_s.cnt = sample ? 4'h0 : s.cnt + 4'h1;
      unique case (s.st)
         ST_VID: begin
            if (sample) begin
               if (s.sel_sync) begin
                  next_s.st = ST_DONE; // serial or absent memory, defaults kept
               end else if (s.addr == VID_LO_ADDR) begin
                  // byte-wide memory path
                  next_s.lo_erased = s.rd_sync == ERASED_BYTE;
                  next_s.addr = VID_HI_ADDR;
               end else if (s.lo_erased && s.rd_sync == ERASED_BYTE) begin
                  next_s.st = ST_DONE;
               end else begin
                  next_s.st = ST_SIG;
                  next_s.addr = SIG_FIRST_ADDR;
               end
            end
         end
         ST_SIG: begin
            if (sample) begin
               if (!sig_ok) begin
                  next_s.st = ST_DONE;
               end else if (s.addr == SIG_LAST_ADDR) begin
                  next_s.st = ST_COPY;
                  next_s.addr = VID_LO_ADDR;
               end else begin
                  next_s.addr = s.addr + 16'h0001;
               end
               if (s.addr == SIG_FIRST_ADDR) begin
                  next_s.bar_tmp = s.rd_sync;
               end
            end
         end
         ST_COPY: begin
            // a full buffer holds the address and retries the sample next clock
            if (sample && s.addr != OPT_ADDR && !fifo_ready) begin
               next_s.cnt = s.cnt;
            end else if (sample) begin
               if (s.addr == OPT_ADDR) begin
                  next_s.opt_tmp = s.rd_sync;
               end
               if (s.addr == IMG_LAST_ADDR) begin
                  next_s.st = ST_DRAIN;
                  next_s.cnt = 4'h0;
               end else begin
                  next_s.addr = s.addr + 16'h0001;
               end
            end
         end
         ST_DRAIN: begin
            next_s.cnt = 4'h0;
            // settings commit only once every byte has left the buffer
            if (!fifo_valid) begin
               next_s.st = ST_DONE;
               next_s.valid = 1'b1;
               next_s.bar = s.bar_tmp;
               next_s.io = s.bar_tmp == BAR0_IO;
               next_s.low1m = s.bar_tmp == BAR0_LOW1M;
               next_s.opt = s.opt_tmp;
            end
         end
         ST_DONE: begin
            next_s.cnt = 4'h0;
         end
      endcase
      next_s.stall = next_s.st != ST_DONE;
      next_s.trdy = cfg_req && !s.stall;
   end

   // reset loads every default and puts address 0040h on the pins
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '{st: ST_VID, addr: VID_LO_ADDR, cnt: 4'h0, lo_erased: 1'b0,
                bar_tmp: BAR0_RESET, opt_tmp: OPT_RESET, rd_meta: 8'h00, rd_sync: 8'h00,
                sel_meta: 1'b0, sel_sync: 1'b0, rst_out_n: 1'b0, stall: 1'b1,
                trdy: 1'b0, valid: 1'b0, bar: BAR0_DEFAULT,
                io: BAR0_DEFAULT == BAR0_IO, low1m: BAR0_DEFAULT == BAR0_LOW1M,
                opt: OPT_RESET};
      end else begin
         s <= next_s;
      end
   end

   cfg_byte_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(push),
      .in_data({s.addr[OFS_W-1:0], s.rd_sync}),
      .in_ready(fifo_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_out),
      .out_ready(cfg_wr_ready)
   );

   // outputs straight from state flops; buffer outputs come from its own flops
   assign addon_reset_out_n = s.rst_out_n; // asserts at once with rst_b
   assign boot_mem_addr = s.addr;
   assign cfg_stall = s.stall;
   assign cfg_trdy = s.trdy;
   assign cfg_wr_valid = fifo_valid;
   assign cfg_wr_offset = fifo_out[ENTRY_W-1:8];
   assign cfg_wr_data = fifo_out[7:0];
   assign boot_valid = s.valid;
   assign bar0_low = s.bar;
   assign bar0_io = s.io;
   assign bar0_below_1m = s.low1m;
   assign opt_byte = s.opt;

   // checks on the sequencer
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_addon_rst_high: assert property (1'b1 |=> addon_reset_out_n)
      else $error("add-on reset still asserted after release");
   a_addr_hold: assert property (s.cnt != 4'h0 |-> $stable(boot_mem_addr))
      else $error("address changed before its eight clocks");
   a_vid_step: assert property (s.st == ST_VID && s.addr == VID_LO_ADDR && sample
      && !s.sel_sync |=> boot_mem_addr == VID_HI_ADDR ##7 s.cnt == WAIT_LAST)
      else $error("second id address not presented for eight clocks");
   a_serial_skip: assert property (s.st == ST_VID && sample && s.sel_sync
      |=> s.st == ST_DONE && !boot_valid)
      else $error("serial select did not skip byte-wide load");
   a_erased_abort: assert property (s.st == ST_VID && s.addr == VID_HI_ADDR && sample
      && !s.sel_sync && s.lo_erased && s.rd_sync == ERASED_BYTE
      |=> s.st == ST_DONE && !boot_valid)
      else $error("erased id did not keep defaults");
   a_sig_start: assert property (s.st == ST_VID && s.addr == VID_HI_ADDR && sample
      && !s.sel_sync && !(s.lo_erased && s.rd_sync == ERASED_BYTE)
      |=> boot_mem_addr == SIG_FIRST_ADDR)
      else $error("signature read did not start at 0050h");
   a_sig_fail: assert property (s.st == ST_SIG && sample && !sig_ok
      |=> s.st == ST_DONE ##1 !boot_valid && !cfg_stall)
      else $error("bad signature did not abandon load");
   a_copy_end: assert property (s.st == ST_COPY && s.addr == IMG_LAST_ADDR && sample
      && fifo_ready |=> s.st == ST_DRAIN)
      else $error("copy did not stop after 007fh");
   a_stall_release: assert property (!cfg_stall |-> s.st == ST_DONE && !fifo_valid)
      else $error("config access released before load ended");
   a_trdy_reply: assert property (cfg_req && !cfg_stall |=> cfg_trdy)
      else $error("access not acknowledged after load");
   a_bar_decode: assert property (boot_valid |-> bar0_io == (bar0_low == BAR0_IO)
      && bar0_below_1m == (bar0_low == BAR0_LOW1M))
      else $error("bar0 space decode wrong");

   c_valid_load: cover property ($rose(boot_valid));
   c_erased_mem: cover property (s.st == ST_VID && s.addr == VID_HI_ADDR && sample
      && s.lo_erased && s.rd_sync == ERASED_BYTE);
   c_copy_stall: cover property (s.st == ST_COPY && sample && !fifo_ready);
endmodule

// [boot_loader_pkg.sv]
// Purpose: shared constants and types for the boot configuration loader
// Assumes: byte-wide boot memory, one clock domain
// Notes: image window is the 64 bytes from vid_lo_addr to img_last_addr
package boot_loader_pkg;
   // boot memory addresses walked by the loader
   localparam logic [15:0] VID_LO_ADDR = 16'h0040;
   localparam logic [15:0] VID_HI_ADDR = 16'h0041;
   localparam logic [15:0] SIG_FIRST_ADDR = 16'h0050;
   localparam logic [15:0] SIG_LAST_ADDR = 16'h0053;
   localparam logic [15:0] IMG_LAST_ADDR = 16'h007f;
   localparam logic [15:0] OPT_ADDR = 16'h0045;
   // byte values that qualify the memory
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] BAR0_MEM = 8'hc0;
   localparam logic [7:0] BAR0_IO = 8'hc1;
   localparam logic [7:0] BAR0_LOW1M = 8'hc2;
   localparam logic [7:0] SIG1_BYTE = 8'hff;
   localparam logic [7:0] SIG2_BYTE = 8'he8;
   localparam logic [7:0] SIG3_BYTE = 8'h10;
   // reset values of the loaded settings
   localparam logic [7:0] BAR0_RESET = 8'hc0;
   localparam logic [7:0] OPT_RESET = 8'h00;
   // clocks from presenting an address to sampling its byte
   localparam logic [3:0] WAIT_CYCLES = 4'h8;
   localparam logic [3:0] WAIT_LAST = WAIT_CYCLES - 4'h1;
   // image offset plus data byte, as pushed into the buffer
   localparam int OFS_W = 6;
   localparam int ENTRY_W = OFS_W + 8;
   localparam int FIFO_DEPTH = 8;
   typedef enum logic [2:0] {
      ST_VID = 3'b000,
      ST_SIG = 3'b001,
      ST_COPY = 3'b010,
      ST_DRAIN = 3'b011,
      ST_DONE = 3'b100
   } load_state_t;
endpackage

// [boot_mem_model.sv]
// Purpose: behavioural byte-wide boot memory on the far side of the loader
// Assumes: read access settles 4 clocks after an address change
// Notes: the bench fills mem directly before each reset
`timescale 1ns/1ps

module boot_mem_model (
   // clock
   input wire logic ref_clk,
   // memory pins
   input wire logic [15:0] addr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:127]; // 64 setup bytes sit at 0040h..007fh
   logic [15:0] last_addr = 16'h0000;
   int age = 0;

   // data toggles while the access settles, so a stale byte is never mistaken for a good one
   initial rdata = 8'h00;
   always @(posedge ref_clk) begin
      if (addr !== last_addr) begin
         last_addr <= addr;
         age <= 0;
         rdata <= ~rdata;
      end else if (age < 3) begin
         age <= age + 1;
         rdata <= ~rdata;
      end else begin
         rdata <= mem[addr[6:0]];
      end
   end
endmodule

// [boot_config_loader_bench.sv]
// Purpose: self-checking bench for the boot configuration loader
// Assumes: inputs change on the falling edge, memory model answers in 4 clocks
// Notes: every scenario starts from its own reset of 16 clocks
`timescale 1ns/1ps

module boot_config_loader_bench;
   import boot_loader_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic boot_type_select = 1'b0;
   logic cfg_req = 1'b0;
   logic cfg_wr_ready = 1'b0;
   logic addon_reset_out_n, cfg_stall, cfg_trdy, cfg_wr_valid;
   logic boot_valid, bar0_io, bar0_below_1m;
   logic [15:0] boot_mem_addr;
   logic [7:0] boot_mem_rdata, cfg_wr_data, bar0_low, opt_byte;
   logic [OFS_W-1:0] cfg_wr_offset;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   boot_config_loader i_boot_config_loader (.ref_clk(ref_clk), .rst_b(rst_b),
      .addon_reset_out_n(addon_reset_out_n), .boot_type_select(boot_type_select),
      .boot_mem_addr(boot_mem_addr), .boot_mem_rdata(boot_mem_rdata), .cfg_req(cfg_req),
      .cfg_stall(cfg_stall), .cfg_trdy(cfg_trdy), .cfg_wr_valid(cfg_wr_valid),
      .cfg_wr_offset(cfg_wr_offset), .cfg_wr_data(cfg_wr_data), .cfg_wr_ready(cfg_wr_ready),
      .boot_valid(boot_valid), .bar0_low(bar0_low), .bar0_io(bar0_io),
      .bar0_below_1m(bar0_below_1m), .opt_byte(opt_byte));

   boot_mem_model i_boot_mem_model (.ref_clk(ref_clk), .addr(boot_mem_addr),
      .rdata(boot_mem_rdata));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard: the whole run needs well under 10000 clocks
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   // valid image; id low byte erased to show one good id byte is enough
   task automatic set_image(input logic [7:0] bar);
      for (int a = 0; a < 128; a++) begin
         i_boot_mem_model.mem[a] = a[7:0] ^ 8'h5a;
      end
      i_boot_mem_model.mem[8'h40] = 8'hff;
      i_boot_mem_model.mem[8'h41] = 8'h12;
      i_boot_mem_model.mem[8'h45] = 8'h3c;
      i_boot_mem_model.mem[8'h50] = bar;
      i_boot_mem_model.mem[8'h51] = 8'hff;
      i_boot_mem_model.mem[8'h52] = 8'he8;
      i_boot_mem_model.mem[8'h53] = 8'h10;
   endtask

   // config request is raised inside reset, so the stall is exercised every time
   task automatic reset_dut(input logic sel);
      @(negedge ref_clk);
      rst_b = 1'b0;
      boot_type_select = sel;
      cfg_req = 1'b1;
      cfg_wr_ready = 1'b0;
      repeat (16) @(negedge ref_clk);
      check(addon_reset_out_n, 1'b0);
      check(cfg_stall, 1'b1);
      check(bar0_low, BAR0_RESET);
      check(opt_byte, OPT_RESET);
      check(boot_valid, 1'b0);
      rst_b = 1'b1;
      @(negedge ref_clk);
      check(addon_reset_out_n, 1'b1);
      check(boot_mem_addr, VID_LO_ADDR);
   endtask

   // load that must end with defaults; top is the highest address it must reach
   task automatic abort_case(input logic sel, input logic [7:0] ia, input logic [7:0] va,
                             input logic [7:0] ib, input logic [7:0] vb,
                             input logic [15:0] top);
      logic [15:0] hi;
      logic early;
      int n;
      set_image(BAR0_IO);
      i_boot_mem_model.mem[ia] = va;
      i_boot_mem_model.mem[ib] = vb;
      reset_dut(sel);
      hi = boot_mem_addr;
      early = 1'b0;
      n = 0;
      repeat (8) @(negedge ref_clk);
      check(boot_mem_addr, sel ? VID_LO_ADDR : VID_HI_ADDR);
      while (cfg_stall === 1'b1 && n < 300) begin
         early = early | cfg_trdy | cfg_wr_valid;
         if (boot_mem_addr > hi) hi = boot_mem_addr;
         n++;
         @(negedge ref_clk);
      end
      check(hi, top);
      check(early, 1'b0);
      check(cfg_stall, 1'b0);
      check(boot_valid, 1'b0);
      check(bar0_low, BAR0_RESET);
      check(opt_byte, OPT_RESET);
      @(negedge ref_clk);
      check(cfg_trdy, 1'b1);
   endtask

   // full copy; a stalled consumer first fills the buffer to refusal
   task automatic good_case(input logic [7:0] bar, input logic stall);
      logic [15:0] a;
      int e;
      int n;
      set_image(bar);
      reset_dut(1'b0);
      if (stall) begin
         repeat (300) @(negedge ref_clk);
         a = boot_mem_addr;
         repeat (40) @(negedge ref_clk);
         check(boot_mem_addr, a);
         check(cfg_wr_valid, 1'b1);
      end
      cfg_wr_ready = 1'b1;
      e = 0;
      n = 0;
      while (boot_valid !== 1'b1 && n < 2000) begin
         check(cfg_trdy, 1'b0);
         if (cfg_wr_valid === 1'b1) begin
            check(cfg_wr_offset, 16'(e));
            check(cfg_wr_data, i_boot_mem_model.mem[64 + e]);
            e = (e == 4) ? 6 : e + 1; // option byte stays internal
         end
         n++;
         @(negedge ref_clk);
      end
      check(16'(e), 16'd64);
      check(boot_valid, 1'b1);
      check(cfg_stall, 1'b0);
      check(bar0_low, bar);
      check(bar0_io, bar == BAR0_IO);
      check(bar0_below_1m, bar == BAR0_LOW1M);
      check(opt_byte, 8'h3c);
      @(negedge ref_clk);
      check(cfg_trdy, 1'b1);
      cfg_req = 1'b0;
      repeat (2) @(negedge ref_clk);
      check(cfg_trdy, 1'b0);
   endtask

   // main sequence
   initial begin
      abort_case(1'b0, 8'h40, 8'hff, 8'h41, 8'hff, VID_HI_ADDR);
      abort_case(1'b1, 8'h7f, 8'h00, 8'h7e, 8'h00, VID_LO_ADDR);
      abort_case(1'b0, 8'h50, 8'h55, 8'h7f, 8'h00, 16'h0050);
      abort_case(1'b0, 8'h51, 8'h00, 8'h7f, 8'h00, 16'h0051);
      abort_case(1'b0, 8'h52, 8'he9, 8'h7f, 8'h00, 16'h0052);
      abort_case(1'b0, 8'h53, 8'h00, 8'h7f, 8'h00, 16'h0053);
      good_case(BAR0_IO, 1'b1);
      good_case(BAR0_LOW1M, 1'b0);
      good_case(BAR0_MEM, 1'b0);
      test_done();
   end
endmodule
